/* File: logic/iap_defines.vh */
// constants for the flash programming sequencer
`ifndef IAP_DEFINES_VH
`define IAP_DEFINES_VH

// =====================================================================
// register byte offsets
`define IAP_OFS_CTRL       8'h00
`define IAP_OFS_BUFCLR     8'h04
`define IAP_OFS_ADDR_LO    8'h08
`define IAP_OFS_ADDR_HI    8'h0C
`define IAP_OFS_DATA_LO    8'h10
`define IAP_OFS_DATA_HI    8'h14
`define IAP_OFS_KEY1_LO    8'h18
`define IAP_OFS_KEY2_LO    8'h1C
`define IAP_OFS_KEY3_LO    8'h20
`define IAP_OFS_KEY1_HI    8'h24
`define IAP_OFS_KEY2_HI    8'h28
`define IAP_OFS_KEY3_HI    8'h2C

// =====================================================================
// control register fields
`define IAP_CTRL_EN_BIT    7
`define IAP_CTRL_MODE_HI   6
`define IAP_CTRL_MODE_LO   4
`define IAP_CTRL_TRIG_BIT  3
`define IAP_CTRL_WT_BIT    2
`define IAP_CTRL_RDEN_BIT  1
`define IAP_CTRL_RD_BIT    0
`define IAP_CTRL_RESET     8'h00

// =====================================================================
// mode codes
`define IAP_MODE_WRITE     3'b000
`define IAP_MODE_ERASE     3'b001
`define IAP_MODE_READ      3'b011
`define IAP_MODE_UNLOCK    3'b110

// =====================================================================
// unlock key pattern
`define IAP_KEY1_LO        8'h00
`define IAP_KEY2_LO        8'h0D
`define IAP_KEY3_LO        8'hC3
`define IAP_KEY1_HI        8'h04
`define IAP_KEY2_HI        8'h09
`define IAP_KEY3_HI        8'h40

// =====================================================================
// timing
`define IAP_CLK_PERIOD_NS  10
`define IAP_PROG_TIME_NS   2200000
`define IAP_PROG_CYCLES    (`IAP_PROG_TIME_NS / `IAP_CLK_PERIOD_NS)
`define IAP_UNLOCK_CYCLES  1000
`define IAP_READ_CYCLES    3
`define IAP_ERASED_WORD    16'h0000

`endif

/* File: logic/iap_sequencer.v */
// flash erase, write and read sequencer with apb register access
`timescale 1ns/100ps
`include "iap_defines.vh"

// Overview of operation
// - mode 110 then trigger bit starts the unlock timer
// - timer expiry clears trigger bit regardless of keys
// - enable flag set only when the whole key pattern matches
// - hardware sets enable flag; software clear disables at once unless hardware sets it in that cycle
// - mode 001 plus initiate erases the addressed page, then clears initiate
// - erased words read back as 0000h
// - mode 000 plus initiate programs the buffered words into the page
// - buffer holds 32 sixteen-bit words, page chosen by address bits 11..5
// - each high byte write below the last word advances the buffer address by one
// - buffer address stops at the last word of the page
// - erase or write keeps initiate high about 2.2 ms
// - cpu halted while read, erase or write runs
// - after buffer clear a repeated write to the same page is allowed
// - read: mode 011, read enable, address, read initiate loads data regs
// - read takes three cycles then read initiate clears
// - reads work without unlocking
// - software cannot set the enable flag
// - buffer clear bit empties the buffer and self clears
module iap_sequencer #(
  parameter PROG_CYCLES   = `IAP_PROG_CYCLES,
  parameter UNLOCK_CYCLES = `IAP_UNLOCK_CYCLES,
  parameter ADDR_W        = 12
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  output reg         cpu_halt_ff
);

  localparam WORDS = 1 << ADDR_W;

  // =====================================================================
  // state
  reg [15:0]       flash_mem [0:WORDS-1];
  reg [15:0]       wbuf      [0:31];
  reg              en_ff;
  reg [2:0]        mode_ff;
  reg              trig_ff;
  reg              wt_ff;
  reg              rden_ff;
  reg              rd_ff;
  reg              bufclr_ff;
  reg [ADDR_W-1:0] addr_ff;
  reg [7:0]        data_lo_ff;
  reg [7:0]        data_hi_ff;
  reg [7:0]        key1_lo_ff;
  reg [7:0]        key2_lo_ff;
  reg [7:0]        key3_lo_ff;
  reg [7:0]        key1_hi_ff;
  reg [7:0]        key2_hi_ff;
  reg [7:0]        key3_hi_ff;
  reg [31:0]       unlock_cnt_ff;
  reg [31:0]       op_cnt_ff;
  reg              op_real_ff;
  reg [2:0]        op_mode_ff;
  reg [31:0]       nxt_prdata;
  reg              nxt_err;
  integer          i;

  // =====================================================================
  // apb decode
  wire       setup   = psel & ~penable;
  wire       access  = psel & penable & pready_ff;
  wire       busy    = wt_ff | rd_ff;
  wire       wr_ok   = access & pwrite & ~pslverr_ff & ~busy;
  wire       wr_ctrl = wr_ok & (paddr == `IAP_OFS_CTRL);
  wire       wr_dhi  = wr_ok & (paddr == `IAP_OFS_DATA_HI);
  wire [2:0] wmode   = pwdata[`IAP_CTRL_MODE_HI:`IAP_CTRL_MODE_LO];
  wire       op_done = busy & (op_cnt_ff == 32'd1);
  wire       unl_end = trig_ff & (unlock_cnt_ff == 32'd1);
  wire [ADDR_W-6:0] page = addr_ff[ADDR_W-1:5];
  // array untouched unless unlocked in write or erase mode
  wire       prog_ok = en_ff & ((wmode == `IAP_MODE_WRITE) | (wmode == `IAP_MODE_ERASE));
  // initiate starts erase, write or a one-cycle no-op
  wire       wt_go   = wr_ctrl & pwdata[`IAP_CTRL_WT_BIT];
  // read needs mode 011, read enable and initiate
  wire       rd_go   = wr_ctrl & ~pwdata[`IAP_CTRL_WT_BIT] & pwdata[`IAP_CTRL_RD_BIT] &
                       pwdata[`IAP_CTRL_RDEN_BIT] & (wmode == `IAP_MODE_READ);
  // trigger only starts an idle timer
  wire       trig_go = wr_ctrl & pwdata[`IAP_CTRL_TRIG_BIT] & ~trig_ff;

  function key_ok;
    input [7:0] a1;
    input [7:0] a2;
    input [7:0] a3;
    input [7:0] b1;
    input [7:0] b2;
    input [7:0] b3;
    begin
      key_ok = (a1 == `IAP_KEY1_LO) && (a2 == `IAP_KEY2_LO) && (a3 == `IAP_KEY3_LO) &&
               (b1 == `IAP_KEY1_HI) && (b2 == `IAP_KEY2_HI) && (b3 == `IAP_KEY3_HI);
    end
  endfunction

  // keys and unlock mode checked at timer expiry
  wire       unl_ok  = unl_end & (mode_ff == `IAP_MODE_UNLOCK) &
                       key_ok(key1_lo_ff, key2_lo_ff, key3_lo_ff,
                              key1_hi_ff, key2_hi_ff, key3_hi_ff);

  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_err    = 1'b0;
    case (paddr)
      `IAP_OFS_CTRL:    nxt_prdata[7:0] = {en_ff, mode_ff, trig_ff, wt_ff, rden_ff, rd_ff};
      `IAP_OFS_BUFCLR:  nxt_prdata[0]   = bufclr_ff;
      `IAP_OFS_ADDR_LO: nxt_prdata[7:0] = addr_ff[7:0];
      `IAP_OFS_ADDR_HI: nxt_prdata[ADDR_W-9:0] = addr_ff[ADDR_W-1:8];
      `IAP_OFS_DATA_LO: nxt_prdata[7:0] = data_lo_ff;
      `IAP_OFS_DATA_HI: nxt_prdata[7:0] = data_hi_ff;
      `IAP_OFS_KEY1_LO: nxt_prdata[7:0] = key1_lo_ff;
      `IAP_OFS_KEY2_LO: nxt_prdata[7:0] = key2_lo_ff;
      `IAP_OFS_KEY3_LO: nxt_prdata[7:0] = key3_lo_ff;
      `IAP_OFS_KEY1_HI: nxt_prdata[7:0] = key1_hi_ff;
      `IAP_OFS_KEY2_HI: nxt_prdata[7:0] = key2_hi_ff;
      `IAP_OFS_KEY3_HI: nxt_prdata[7:0] = key3_hi_ff;
      default:          nxt_err = 1'b1;
    endcase
  end

  // =====================================================================
  // apb answer, one wait-free access cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_err;
      if (setup & ~pwrite)
        prdata_ff <= nxt_prdata;
    end
  end

  // =====================================================================
  // control, unlock and operation sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff         <= 1'b0;
      mode_ff       <= 3'b000;
      trig_ff       <= 1'b0;
      wt_ff         <= 1'b0;
      rden_ff       <= 1'b0;
      rd_ff         <= 1'b0;
      bufclr_ff     <= 1'b0;
      unlock_cnt_ff <= 32'd0;
      op_cnt_ff     <= 32'd0;
      op_real_ff    <= 1'b0;
      op_mode_ff    <= 3'b000;
      addr_ff       <= {ADDR_W{1'b0}};
      data_lo_ff    <= 8'h00;
      data_hi_ff    <= 8'h00;
      key1_lo_ff    <= 8'h00;
      key2_lo_ff    <= 8'h00;
      key3_lo_ff    <= 8'h00;
      key1_hi_ff    <= 8'h00;
      key2_hi_ff    <= 8'h00;
      key3_hi_ff    <= 8'h00;
    end else begin
      if (bufclr_ff)
        bufclr_ff <= 1'b0;
      if (trig_ff)
        unlock_cnt_ff <= unlock_cnt_ff - 32'd1;
      if (busy)
        op_cnt_ff <= op_cnt_ff - 32'd1;
      if (unl_end)
        trig_ff <= 1'b0;
      if (wr_ok) begin
        case (paddr)
          `IAP_OFS_CTRL: begin
            mode_ff <= wmode;
            rden_ff <= pwdata[`IAP_CTRL_RDEN_BIT];
            if (!pwdata[`IAP_CTRL_EN_BIT])
              en_ff <= 1'b0;
            if (trig_go) begin
              trig_ff       <= 1'b1;
              unlock_cnt_ff <= UNLOCK_CYCLES;
            end
            if (wt_go) begin
              wt_ff       <= 1'b1;
              op_mode_ff  <= wmode;
              // locked or reserved mode is a no-op
              if (prog_ok) begin
                op_real_ff <= 1'b1;
                op_cnt_ff  <= PROG_CYCLES;
              end else begin
                op_real_ff <= 1'b0;
                op_cnt_ff  <= 32'd1;
              end
            end else if (rd_go) begin
              rd_ff       <= 1'b1;
              op_real_ff  <= 1'b1;
              op_mode_ff  <= wmode;
              op_cnt_ff   <= `IAP_READ_CYCLES;
            end
          end
          `IAP_OFS_BUFCLR:  bufclr_ff <= pwdata[0];
          `IAP_OFS_ADDR_LO: addr_ff[7:0] <= pwdata[7:0];
          `IAP_OFS_ADDR_HI: addr_ff[ADDR_W-1:8] <= pwdata[ADDR_W-9:0];
          `IAP_OFS_DATA_LO: data_lo_ff <= pwdata[7:0];
          `IAP_OFS_DATA_HI: begin
            data_hi_ff <= pwdata[7:0];
            if (addr_ff[4:0] != 5'h1F)
              addr_ff <= addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
          `IAP_OFS_KEY1_LO: key1_lo_ff <= pwdata[7:0];
          `IAP_OFS_KEY2_LO: key2_lo_ff <= pwdata[7:0];
          `IAP_OFS_KEY3_LO: key3_lo_ff <= pwdata[7:0];
          `IAP_OFS_KEY1_HI: key1_hi_ff <= pwdata[7:0];
          `IAP_OFS_KEY2_HI: key2_hi_ff <= pwdata[7:0];
          `IAP_OFS_KEY3_HI: key3_hi_ff <= pwdata[7:0];
          default: ;
        endcase
      end
      // set only on full key match
      // only hardware sets, and set wins over clear
      if (unl_ok)
        en_ff <= 1'b1;
      if (op_done) begin
        wt_ff       <= 1'b0;
        rd_ff       <= 1'b0;
        if (rd_ff) begin
          data_lo_ff <= flash_mem[addr_ff][7:0];
          data_hi_ff <= flash_mem[addr_ff][15:8];
        end
      end
    end
  end

  // =====================================================================
  // cpu stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt_ff <= 1'b0;
    end else begin
      // stall from operation start to completion
      if (wt_go | rd_go)
        cpu_halt_ff <= 1'b1;
      else if (op_done)
        cpu_halt_ff <= 1'b0;
    end
  end

  // =====================================================================
  // write buffer and flash array
  always @(posedge pclk) begin
    if (wr_dhi)
      wbuf[addr_ff[4:0]] <= {pwdata[7:0], data_lo_ff};
    if (bufclr_ff) begin
      for (i = 0; i < 32; i = i + 1) begin
        wbuf[i] <= `IAP_ERASED_WORD;
      end
    end
    if (op_done && wt_ff && op_real_ff) begin
      for (i = 0; i < 32; i = i + 1) begin
        if (op_mode_ff == `IAP_MODE_ERASE)
          flash_mem[{page, i[4:0]}] <= `IAP_ERASED_WORD;
        else
          flash_mem[{page, i[4:0]}] <= flash_mem[{page, i[4:0]}] | wbuf[i];
      end
    end
  end

endmodule

/* File: verification/iap_seq_checker.sv */
// port assertions for the flash sequencer
`timescale 1ns/100ps
module iap_seq_checker #(
  parameter PROG_CYCLES = 20
) (
  input logic       pclk,
  input logic       presetn,
  input logic       psel,
  input logic       penable,
  input logic       pwrite,
  input logic [7:0] paddr,
  input logic [7:0] pwdata,
  input logic       pready_ff,
  input logic       pslverr_ff,
  input logic       cpu_halt_ff
);
  // ====
  // helper logic
  logic [31:0] hcnt_ff;
  wire ctl_wr = psel && penable && pready_ff && pwrite && paddr == 8'h00 && !cpu_halt_ff;
  wire bad    = paddr > 8'h2C || paddr[1:0] != 2'b00;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hcnt_ff <= 32'h0000_0000;
    else
      hcnt_ff <= cpu_halt_ff ? hcnt_ff + 32'h0000_0001 : 32'h0000_0000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // assertions
  setup_ready_a: assert property (psel && !penable |=> pready_ff)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (psel && !penable && bad |=> pslverr_ff)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (psel && !penable && !bad |=> !pslverr_ff)
    else $error("error on mapped address");
  halt_start_a: assert property (ctl_wr && pwdata[2] |=> cpu_halt_ff)
    else $error("no halt after initiate");
  read_time_a: assert property (ctl_wr && pwdata[6:0] == 7'h33 |=> cpu_halt_ff [*3] ##1 !cpu_halt_ff)
    else $error("read halt not three cycles");
  halt_len_a: assert property ($fell(cpu_halt_ff) |-> hcnt_ff == 1 || hcnt_ff == 3 || hcnt_ff == PROG_CYCLES)
    else $error("wrong halt length");
  halt_max_a: assert property (hcnt_ff <= PROG_CYCLES)
    else $error("halt too long");
  cover property (ctl_wr && pwdata[6:0] == 7'h33);
  cover property ($fell(cpu_halt_ff) && hcnt_ff == PROG_CYCLES);
  cover property (psel && !penable && bad);
endmodule
bind iap_sequencer iap_seq_checker #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata[7:0]), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .cpu_halt_ff(cpu_halt_ff));

/* File: verification/iap_sequencer_tb.sv */
// self-checking bench for the flash sequencer
`timescale 1ns/100ps
`include "iap_defines.vh"
module iap_sequencer_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata_ff, rdat;
  logic        pready_ff, pslverr_ff, cpu_halt_ff, rhalt;
  int          miscompares = 0, samples_checked = 0, i;
  logic [7:0]  kofs [6] = '{`IAP_OFS_KEY1_LO, `IAP_OFS_KEY2_LO, `IAP_OFS_KEY3_LO,
                            `IAP_OFS_KEY1_HI, `IAP_OFS_KEY2_HI, `IAP_OFS_KEY3_HI};
  logic [7:0]  kval [6] = '{`IAP_KEY1_LO, `IAP_KEY2_LO, `IAP_KEY3_LO,
                            `IAP_KEY1_HI, `IAP_KEY2_HI, `IAP_KEY3_HI};
  always #5 pclk = ~pclk;
  iap_sequencer #(.PROG_CYCLES(20), .UNLOCK_CYCLES(64)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .cpu_halt_ff(cpu_halt_ff));
  // ====
  // tasks
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end
    rdat = prdata_ff;
    rhalt = cpu_halt_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_clr(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      xfer(0, `IAP_OFS_CTRL, 8'h00);
      n++;
    end while ((rdat[7:0] & m) !== 8'h00 && n < 100);
    if (n >= 100) begin
      miscompares++;
      print_verdict();
    end
    chk({31'h0000_0000, rhalt}, 32'h0000_0000);
  endtask
  task automatic set_addr(input logic [11:0] a);
    xfer(1, `IAP_OFS_ADDR_LO, a[7:0]);
    xfer(1, `IAP_OFS_ADDR_HI, {4'h0, a[11:8]});
  endtask
  task automatic wdat(input logic [15:0] d);
    xfer(1, `IAP_OFS_DATA_LO, d[7:0]);
    xfer(1, `IAP_OFS_DATA_HI, d[15:8]);
  endtask
  task automatic rdword(input logic [11:0] a, input logic [15:0] e, input logic en);
    logic [7:0] lo;
    set_addr(a);
    xfer(1, `IAP_OFS_CTRL, {en, 7'h32});
    xfer(1, `IAP_OFS_CTRL, {en, 7'h33});
    wait_clr(8'h01);
    xfer(0, `IAP_OFS_DATA_LO, 8'h00);
    lo = rdat[7:0];
    xfer(0, `IAP_OFS_DATA_HI, 8'h00);
    chk({16'h0000, rdat[7:0], lo}, {16'h0000, e});
  endtask
  // ====
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 8'h30, 8'h00);
    xfer(1, `IAP_OFS_CTRL, 8'h80);
    xfer(0, `IAP_OFS_CTRL, 8'h00);
    chk(rdat, 32'h0000_0000);
    xfer(1, `IAP_OFS_CTRL, 8'h60);
    xfer(1, `IAP_OFS_CTRL, 8'h68);
    xfer(1, `IAP_OFS_KEY1_LO, 8'h01);
    xfer(1, `IAP_OFS_CTRL, 8'h68);
    wait_clr(8'h08);
    chk(rdat, 32'h0000_0060);
    xfer(1, `IAP_OFS_CTRL, 8'h68);
    for (i = 0; i < 6; i++)
      xfer(1, kofs[i], kval[i]);
    wait_clr(8'h08);
    chk(rdat, 32'h0000_00E0);
    $display("test unlock done");
    set_addr(12'h040);
    xfer(1, `IAP_OFS_CTRL, 8'h94);
    xfer(0, `IAP_OFS_CTRL, 8'h00);
    chk({31'h0000_0000, rhalt}, 32'h0000_0001);
    wait_clr(8'h04);
    chk(rdat, 32'h0000_0090);
    rdword(12'h05F, `IAP_ERASED_WORD, 1'b1);
    xfer(1, `IAP_OFS_CTRL, 8'h80);
    set_addr(12'h040);
    for (i = 0; i < 33; i++)
      wdat(16'h1100 + i[15:0]);
    xfer(1, `IAP_OFS_CTRL, 8'h84);
    wait_clr(8'h04);
    rdword(12'h040, 16'h1100, 1'b1);
    rdword(12'h041, 16'h1101, 1'b1);
    rdword(12'h05F, 16'h1120, 1'b1);
    $display("test write done");
    xfer(1, `IAP_OFS_BUFCLR, 8'h01);
    xfer(0, `IAP_OFS_BUFCLR, 8'h00);
    chk(rdat, 32'h0000_0000);
    xfer(1, `IAP_OFS_CTRL, 8'h80);
    set_addr(12'h042);
    wdat(16'h0F0F);
    xfer(1, `IAP_OFS_CTRL, 8'h84);
    wait_clr(8'h04);
    rdword(12'h042, 16'h1F0F, 1'b1);
    rdword(12'h043, 16'h1103, 1'b1);
    $display("test rewrite done");
    xfer(1, `IAP_OFS_CTRL, 8'h00);
    xfer(0, `IAP_OFS_CTRL, 8'h00);
    chk(rdat, 32'h0000_0000);
    set_addr(12'h041);
    wdat(16'hFFFF);
    xfer(1, `IAP_OFS_CTRL, 8'h04);
    wait_clr(8'h04);
    rdword(12'h041, 16'h1101, 1'b0);
    $display("test locked done");
    print_verdict();
  end
endmodule
